//--- rx_ctrl_pkg.sv
// Package: register map, field positions and reset values of the receive control bank
package rx_ctrl_pkg;
  localparam int unsigned NUM_CHANNELS = 3;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned REG_W        = 8;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] RX_CTRL_IDX_CH0 = 8'h05;
  localparam logic [ADDR_W-1:0] RX_CTRL_IDX_CH1 = 8'h0d;
  localparam logic [ADDR_W-1:0] RX_CTRL_IDX_CH2 = 8'h15;
  // Status register: live per-channel loss-of-signal declaration
  localparam logic [ADDR_W-1:0] RX_STAT_IDX     = 8'h1f;

  localparam int unsigned EQ_EN_BIT   = 0;
  localparam int unsigned MON_MODE_BIT = 1;
  localparam int unsigned MUTE_BIT     = 2;
  localparam int unsigned RW_FIELD_W   = 3;

  localparam logic [REG_W-1:0] RX_CTRL_RESET = 8'h00;
  localparam logic [1:0]       APB_WAIT_CYCLES = 2'h0;

  // Byte address of a register index
  function automatic logic [ADDR_W+1:0] idx_to_addr(
    input logic [ADDR_W-1:0] idx
  );
    idx_to_addr = {idx, 2'b00};
  endfunction
endpackage

//--- rx_chan_gate.sv
// One channel: loss-of-signal suppression and recovered data muting
module rx_chan_gate (
  // Configuration
  input  wire logic mute_on_signal_loss,
  input  wire logic monitor_mode,
  // Detector and recovered data
  input  wire logic los_detect,
  input  wire logic rec_pos,
  input  wire logic rec_neg,
  // Outputs
  output logic      los_declared,
  output logic      recovered_positive_rail_out,
  output logic      recovered_negative_rail_out
);
  logic mute;

  always_comb
  begin
    // Monitor mode masks the detector entirely
    los_declared = los_detect & ~monitor_mode;               // [R4]
    // Combinational gating: no unmuted bit leaks after declaration
    mute = mute_on_signal_loss & los_declared;               // [R1] [R8]
    // With muting disabled the data passes unchanged
    recovered_positive_rail_out = rec_pos & ~mute;           // [R2]
    recovered_negative_rail_out = rec_neg & ~mute;           // [R2]
  end
endmodule

//--- rx_los_mute_monitor_ctrl.sv
// Receive control bank: APB registers and per-channel LOS/mute/monitor logic
//
// How it works
// [R1] Mute bit set: both recovered data outputs low while LOS is declared.
// [R2] Mute bit clear: recovered data passes unchanged even during LOS.
// [R3] Monitor bit selects normal (0) or monitor mode (1) per channel.
// [R4] In monitor mode LOS detection is suppressed; LOS never declared.
// [R5] Equalizer bit turns the channel's receive equalizer off (0) or on (1).
// [R6] Software should set equalizer enable to 1 on all three channels.
// [R7] Control registers at indices 0x05, 0x0d, 0x15; all fields reset 0.
// [R8] Muting follows the LOS declaration combinationally, no leakage.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
module rx_los_mute_monitor_ctrl
  import rx_ctrl_pkg::*;
#(
  parameter int unsigned CHANNELS = rx_ctrl_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [rx_ctrl_pkg::ADDR_W+1:0]    paddr,
  input  wire logic [rx_ctrl_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [rx_ctrl_pkg::DATA_W-1:0]    prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Receive path per channel
  input  wire logic [CHANNELS-1:0]               los_detect,
  input  wire logic [CHANNELS-1:0]               rec_pos,
  input  wire logic [CHANNELS-1:0]               rec_neg,
  // Channel outputs
  output logic      [CHANNELS-1:0]               recovered_positive_rail_out,
  output logic      [CHANNELS-1:0]               recovered_negative_rail_out,
  output logic      [CHANNELS-1:0]               los_declared,
  output logic      [CHANNELS-1:0]               equalizer_enable,
  output logic      [CHANNELS-1:0]               monitor_mode
);
  import rx_ctrl_pkg::*;

  logic [RW_FIELD_W-1:0] ctrl_q [CHANNELS];
  logic [RW_FIELD_W-1:0] ctrl_d [CHANNELS];
  logic [DATA_W-1:0]     prdata_q;
  logic [DATA_W-1:0]     prdata_d;
  logic                  pslverr_q;
  logic                  pslverr_d;
  logic                  access;
  logic                  addr_ok;
  logic [1:0]            sel_ch;
  logic [1:0]            sel_ch_q;
  logic                  sel_ctrl;
  logic                  sel_stat;

  // Address decode
  always_comb
  begin
    sel_ctrl = 1'b1;
    sel_stat = 1'b0;
    sel_ch   = 2'h0;
    case (paddr)
      idx_to_addr(RX_CTRL_IDX_CH0): sel_ch = 2'h0;          // [R7]
      idx_to_addr(RX_CTRL_IDX_CH1): sel_ch = 2'h1;          // [R7]
      idx_to_addr(RX_CTRL_IDX_CH2): sel_ch = 2'h2;          // [R7]
      idx_to_addr(RX_STAT_IDX):
      begin
        sel_ctrl = 1'b0;
        sel_stat = 1'b1;
      end
      default:
        sel_ctrl = 1'b0;
    endcase
    addr_ok = sel_ctrl | sel_stat;
  end

  // Zero-wait slave: every access completes in its first access cycle
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      ctrl_d[i] = ctrl_q[i];
    end
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel & ~penable)
    begin
      // Setup cycle: prepare read data and error for the access cycle
      pslverr_d = ~addr_ok;
      prdata_d  = '0;
      if (!pwrite && sel_ctrl)
      begin
        prdata_d[RW_FIELD_W-1:0] = ctrl_q[sel_ch];
      end
      else if (!pwrite && sel_stat)
      begin
        prdata_d[CHANNELS-1:0] = los_declared;
      end
    end
    else if (access)
    begin
      pslverr_d = pslverr_q;
      // Unused upper bits are read-only and stay zero
      if (pwrite && sel_ctrl && pstrb[0])
      begin
        ctrl_d[sel_ch] = pwdata[RW_FIELD_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        ctrl_q[i] <= RX_CTRL_RESET[RW_FIELD_W-1:0];          // [R7]
      end
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        ctrl_q[i] <= ctrl_d[i];
      end
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Remembers which channel the previous cycle addressed
  always_ff @(posedge sys_clk)
  begin
    sel_ch_q <= sel_ch;
  end

  // Access cycle of a write to a control register
  sequence s_ctrl_write;
    psel && penable && pwrite && sel_ctrl && pstrb[0];
  endsequence

  // Setup cycles of reads from a control or the status register
  sequence s_ctrl_rd_setup;
    psel && !penable && !pwrite && sel_ctrl;
  endsequence

  sequence s_stat_rd_setup;
    psel && !penable && !pwrite && sel_stat;
  endsequence

  // Setup cycle to an address that maps to no register
  sequence s_bad_setup;
    psel && !penable && !addr_ok;
  endsequence

  // Per-channel receive gating
  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_ch
    assign equalizer_enable[c] = ctrl_q[c][EQ_EN_BIT];      // [R5]
    assign monitor_mode[c]     = ctrl_q[c][MON_MODE_BIT];   // [R3]

    rx_chan_gate u_gate (
      .mute_on_signal_loss         (ctrl_q[c][MUTE_BIT]),
      .monitor_mode                (ctrl_q[c][MON_MODE_BIT]),
      .los_detect                  (los_detect[c]),
      .rec_pos                     (rec_pos[c]),
      .rec_neg                     (rec_neg[c]),
      .los_declared                (los_declared[c]),
      .recovered_positive_rail_out (recovered_positive_rail_out[c]),
      .recovered_negative_rail_out (recovered_negative_rail_out[c])
    );

    AST_MUTE_LOW: assert property ( // [R1]
      @(posedge sys_clk) disable iff (!rst_n)
      (ctrl_q[c][MUTE_BIT] && los_declared[c]) |->
        !recovered_positive_rail_out[c] && !recovered_negative_rail_out[c])
      else $error("data not muted during loss");
    AST_PASS_THRU: assert property ( // [R2]
      @(posedge sys_clk) disable iff (!rst_n)
      !ctrl_q[c][MUTE_BIT] |->
        recovered_positive_rail_out[c] == rec_pos[c] &&
        recovered_negative_rail_out[c] == rec_neg[c])
      else $error("data altered with muting off");
    AST_MON_SEL: assert property ( // [R3]
      @(posedge sys_clk) disable iff (!rst_n)
      s_ctrl_write ##0 (sel_ch == 2'(c)) |=>
        monitor_mode[c] == $past(pwdata[MON_MODE_BIT]))
      else $error("monitor mode bit not written");
    AST_MON_NO_LOS: assert property ( // [R4]
      @(posedge sys_clk) disable iff (!rst_n)
      monitor_mode[c] |-> !los_declared[c])
      else $error("loss declared in monitor mode");
    AST_LOS_NORMAL: assert property ( // [R4]
      @(posedge sys_clk) disable iff (!rst_n)
      !monitor_mode[c] |-> los_declared[c] == los_detect[c])
      else $error("loss not declared in normal mode");
    AST_NO_LEAK: assert property ( // [R8]
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(los_declared[c]) && ctrl_q[c][MUTE_BIT] |->
        !recovered_positive_rail_out[c])
      else $error("data leaked after declaration");
  end

  AST_EQ_WRITE: assert property ( // [R5]
    @(posedge sys_clk) disable iff (!rst_n)
    s_ctrl_write ##1 1'b1 |->
      equalizer_enable[sel_ch_q] == $past(pwdata[EQ_EN_BIT]))
    else $error("equalizer bit not written");

  AST_RESET_ZERO: assert property ( // [R7]
    @(posedge sys_clk)
    !rst_n |=> ctrl_q[0] == '0 && ctrl_q[1] == '0 && ctrl_q[2] == '0)
    else $error("control fields not zero after reset");
  AST_RD_BACK: assert property ( // [R7]
    @(posedge sys_clk) disable iff (!rst_n)
    s_ctrl_rd_setup ##1 penable |->
      prdata[RW_FIELD_W-1:0] == ctrl_q[sel_ch_q] &&
      prdata[DATA_W-1:RW_FIELD_W] == '0)
    else $error("readback mismatch");
  AST_STAT_READ: assert property ( // [R4]
    @(posedge sys_clk) disable iff (!rst_n)
    s_stat_rd_setup ##1 penable |->
      prdata[CHANNELS-1:0] == $past(los_declared) &&
      prdata[DATA_W-1:CHANNELS] == '0)
    else $error("status read does not show the loss declaration");
  AST_BAD_ADDR: assert property ( // [R7]
    @(posedge sys_clk) disable iff (!rst_n)
    s_bad_setup ##1 penable |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  AST_BAD_WRITE: assert property ( // [R7]
    @(posedge sys_clk) disable iff (!rst_n)
    psel && penable && pwrite && !sel_ctrl |=>
      equalizer_enable == $past(equalizer_enable) &&
      monitor_mode == $past(monitor_mode))
    else $error("write outside the control registers changed a field");
endmodule

//--- rx_framer_model.sv
// Framer-side model: captures the recovered rails on every clock
module rx_framer_model (
  // Clock
  input  wire logic       sys_clk,
  // Recovered rails
  input  wire logic [2:0] pos_in,
  input  wire logic [2:0] neg_in,
  // Captured data
  output logic      [2:0] pos_seen,
  output logic      [2:0] neg_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge sys_clk)
  begin
    pos_seen <= pos_in;
    neg_seen <= neg_in;
  end
endmodule

//--- rx_los_mute_monitor_ctrl_tb.sv
// Testbench of the receive control bank
module rx_los_mute_monitor_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rx_ctrl_pkg::*;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err;
  logic [2:0]  los = 0, rp = 0, rn = 0, po, no, ld, eq, mon, ps, ns, v;
  logic [15:0] lf = 16'h2a70;
  logic [8:0]  e;
  logic [2:0]  cfg [3] = '{default: 3'h0};
  logic [7:0]  idx [3] = '{RX_CTRL_IDX_CH0, RX_CTRL_IDX_CH1, RX_CTRL_IDX_CH2};
  int          num_errors = 0, compares = 0, cyc = 0, ch;

  rx_los_mute_monitor_ctrl #(.CHANNELS(3)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .los_detect(los), .rec_pos(rp),
    .rec_neg(rn), .recovered_positive_rail_out(po),
    .recovered_negative_rail_out(no), .los_declared(ld),
    .equalizer_enable(eq), .monitor_mode(mon));
  rx_framer_model framer (.sys_clk(sys_clk), .pos_in(po), .neg_in(no),
    .pos_seen(ps), .neg_seen(ns));

  initial forever #25 sys_clk = ~sys_clk;

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected {declared, positive, negative} from the programmed bits
  function automatic logic [8:0] ex(input logic [2:0] l, p, n);
    logic [2:0] d, mu;
    for (int c = 0; c < 3; c++)
    begin
      d[c]  = l[c] & ~cfg[c][1];
      mu[c] = d[c] & cfg[c][2];
    end
    return {d, p & ~mu, n & ~mu};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] a, input logic [2:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {29'h0, d};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      finish_test;
    end
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    // Unmapped write must be refused and leave every field at reset
    apb(1, 10'h3fc, 3'h7);
    chk({31'h0, err}, 32'h1);
    apb(0, 10'h3fc, 3'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      apb(0, {idx[c], 2'b00}, 3'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 60; i++)
    begin
      lf = nx(lf);
      ch = (i < 3) ? i : lf % 3;
      v = (i < 3) ? 3'h5 : lf[6:4];
      apb(1, {idx[ch], 2'b00}, v);
      cfg[ch] = v;
      apb(0, {idx[ch], 2'b00}, 3'h0);
      chk(rd, {29'h0, v});
      lf = nx(lf);
      los <= (i < 6) ? 3'h7 : lf[2:0];
      rp <= lf[5:3];
      rn <= lf[8:6];
      @(negedge sys_clk);
      e = ex(los, rp, rn);
      chk(ld, e[8:6]);
      chk({po, no}, e[5:0]);
      chk(eq, {cfg[2][0], cfg[1][0], cfg[0][0]});
      chk(mon, {cfg[2][1], cfg[1][1], cfg[0][1]});
      @(posedge sys_clk);
      #1;
      chk({ps, ns}, e[5:0]);
      apb(0, {RX_STAT_IDX, 2'b00}, 3'h0);
      chk(rd, {29'h0, e[8:6]});
    end
    finish_test;
  end
endmodule
